// *** shared/reload_event_timer_pkg.sv ***
package reload_event_timer_pkg;
    // register map, plain port addresses
    localparam int ADDR_W = 6;
    localparam logic [5:0] ADDR_FLAG = 6'h02;
    localparam logic [5:0] ADDR_MODE_ONE = 6'h09;
    localparam logic [5:0] ADDR_LOW = 6'h0A;
    localparam logic [5:0] ADDR_HIGH = 6'h0B;
    localparam logic [5:0] ADDR_OUT_MODE = 6'h13;
    localparam logic [5:0] ADDR_PIN_FUNC = 6'h25;

    // field positions
    localparam int FLAG_BIT = 0;
    localparam int RELOAD_BIT = 3;
    localparam int EVENT_SEL_BIT = 0;
    localparam int SECOND_EVENT_BIT = 1;
    localparam int STOP_CTRL_BIT = 2;
    localparam int EXT_INT_BIT = 3;

    // reset values, full count and free-running wrap value
    localparam logic [3:0] MODE_ONE_RST = 4'h0;
    localparam logic [3:0] PRELOAD_RST = 4'h0;
    localparam logic [1:0] OUT_MODE_RST = 2'h0;
    localparam logic [3:0] PIN_FUNC_RST = 4'h0;
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [7:0] COUNT_MAX = 8'hFF;
    localparam logic [7:0] COUNT_WRAP = 8'h00;

    // count clock select codes and prescaler tap widths (period = 2**bits)
    localparam logic [2:0] SEL_EVENT = 3'h7;
    localparam int PRESCALE_W = 11;
    localparam int TAP_2048 = 11;
    localparam int TAP_512 = 9;
    localparam int TAP_128 = 7;
    localparam int TAP_32 = 5;
    localparam int TAP_8 = 3;
    localparam int TAP_4 = 2;
    localparam int TAP_2 = 1;

    // output pin function
    typedef enum logic [1:0] {
        OUT_PORT = 2'h0,
        OUT_TOGGLE = 2'h1,
        OUT_FORCE_LOW = 2'h2,
        OUT_FORCE_HIGH = 2'h3
    } out_mode_t;
endpackage

// *** logic/reload_event_timer.sv ***
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module reload_event_timer (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [5:0] reg_addr,
    input wire logic [3:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [3:0] reg_rdata,
    input wire logic event_input_pin,
    output logic timer_output_pin,
    output logic timer_output_en,
    output logic overflow_request_flag,
    output logic event_pin_select,
    output logic second_event_select,
    output logic stop_control_select,
    output logic external_interrupt_select
);
    // software state
    logic [3:0] mode_stage;
    logic [3:0] timer_mode_one;
    logic [3:0] preload_low_nibble;
    logic [3:0] preload_high_nibble;
    logic [1:0] timer_output_mode;
    logic [3:0] pin_function_select;
    logic [3:0] count_low_latched;
    // timer state
    logic [7:0] count;
    logic [10:0] prescale;
    logic evt_meta;
    logic evt_sync;
    logic evt_prev;
    logic out_level;
    logic out_en;
    logic flag;
    logic [3:0] rdata;

    // address decode
    wire wr_flag = reg_wr && (reg_addr == reload_event_timer_pkg::ADDR_FLAG);
    wire wr_mode = reg_wr && (reg_addr == reload_event_timer_pkg::ADDR_MODE_ONE);
    wire wr_low = reg_wr && (reg_addr == reload_event_timer_pkg::ADDR_LOW);
    wire wr_high = reg_wr && (reg_addr == reload_event_timer_pkg::ADDR_HIGH);
    wire wr_out = reg_wr && (reg_addr == reload_event_timer_pkg::ADDR_OUT_MODE);
    wire wr_pin = reg_wr && (reg_addr == reload_event_timer_pkg::ADDR_PIN_FUNC);
    wire rd_low = reg_rd && (reg_addr == reload_event_timer_pkg::ADDR_LOW);
    wire rd_high = reg_rd && (reg_addr == reload_event_timer_pkg::ADDR_HIGH);
    wire rd_out = reg_rd && (reg_addr == reload_event_timer_pkg::ADDR_OUT_MODE);
    wire rd_flag = reg_rd && (reg_addr == reload_event_timer_pkg::ADDR_FLAG);

    // true when the low tap_bits bits of the prescaler are all ones
    function automatic logic tap_hit(input logic [10:0] pre, input int tap_bits);
        logic [10:0] mask;
        mask = 11'h7FF >> (reload_event_timer_pkg::PRESCALE_W - tap_bits);
        return (pre & mask) == mask;
    endfunction

    // count clock selection
    wire [2:0] clk_sel = timer_mode_one[2:0];
    wire reload_on = timer_mode_one[reload_event_timer_pkg::RELOAD_BIT];
    wire event_fall = evt_prev && !evt_sync;
    logic tick;
    always_comb begin
        unique case (clk_sel)
            3'h0: tick = tap_hit(prescale, reload_event_timer_pkg::TAP_2048);
            3'h1: tick = tap_hit(prescale, reload_event_timer_pkg::TAP_512);
            3'h2: tick = tap_hit(prescale, reload_event_timer_pkg::TAP_128);
            3'h3: tick = tap_hit(prescale, reload_event_timer_pkg::TAP_32);
            3'h4: tick = tap_hit(prescale, reload_event_timer_pkg::TAP_8);
            3'h5: tick = tap_hit(prescale, reload_event_timer_pkg::TAP_4);
            3'h6: tick = tap_hit(prescale, reload_event_timer_pkg::TAP_2);
            // pin only counts once it is assigned to the event function
            3'h7: tick = event_fall && pin_function_select[0];
        endcase
    end

    // a software load takes the counter and swallows a tick in the same cycle
    wire load = wr_high;
    wire at_max = (count == reload_event_timer_pkg::COUNT_MAX);
    wire overflow = tick && at_max && !load;
    wire [7:0] reload_value = {preload_high_nibble, preload_low_nibble};
    wire [7:0] wrap_value = reload_on ? reload_value : reload_event_timer_pkg::COUNT_WRAP;
    wire [7:0] next_count = load ? {reg_wdata, preload_low_nibble} :
        overflow ? wrap_value :
        tick ? count + 8'h01 : count;

    // output pin level on overflow
    wire [1:0] out_mode = timer_output_mode;
    logic next_out_level;
    always_comb begin
        next_out_level = out_level;
        if (overflow) begin
            unique case (out_mode)
                reload_event_timer_pkg::OUT_PORT: next_out_level = out_level;
                reload_event_timer_pkg::OUT_TOGGLE: next_out_level = !out_level;
                reload_event_timer_pkg::OUT_FORCE_LOW: next_out_level = 1'b0;
                reload_event_timer_pkg::OUT_FORCE_HIGH: next_out_level = 1'b1;
            endcase
        end
    end

    // flag: hardware set wins over a software clear in the same cycle
    wire flag_clear = wr_flag && !reg_wdata[reload_event_timer_pkg::FLAG_BIT];
    wire next_flag = overflow || (flag && !flag_clear);

    // read mux; write-only and unmapped addresses read zero
    wire [3:0] next_rdata = rd_high ? count[7:4] :
        rd_low ? count_low_latched :
        rd_out ? {2'h0, timer_output_mode} :
        rd_flag ? {3'h0, flag} : 4'h0;

    // event pin synchroniser; first stage feeds only the second
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            evt_meta <= 1'b1;
            evt_sync <= 1'b1;
            evt_prev <= 1'b1;
        end else begin
            evt_meta <= event_input_pin;
            evt_sync <= evt_meta;
            evt_prev <= evt_sync;
        end
    end

    // free-running prescaler, restarted only by reset
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            prescale <= 11'h000;
        end else begin
            prescale <= prescale + 11'h001;
        end
    end

    // mode register: a write is staged one cycle, so it rules from the second cycle
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            mode_stage <= reload_event_timer_pkg::MODE_ONE_RST;
            timer_mode_one <= reload_event_timer_pkg::MODE_ONE_RST;
        end else begin
            if (wr_mode) begin
                mode_stage <= reg_wdata;
            end
            timer_mode_one <= mode_stage;
        end
    end

    // preload, output mode and pin function registers
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            preload_low_nibble <= reload_event_timer_pkg::PRELOAD_RST;
            preload_high_nibble <= reload_event_timer_pkg::PRELOAD_RST;
            timer_output_mode <= reload_event_timer_pkg::OUT_MODE_RST;
            pin_function_select <= reload_event_timer_pkg::PIN_FUNC_RST;
        end else begin
            if (wr_low) begin
                preload_low_nibble <= reg_wdata;
            end
            if (wr_high) begin
                preload_high_nibble <= reg_wdata;
            end
            if (wr_out) begin
                timer_output_mode <= reg_wdata[1:0];
            end
            if (wr_pin) begin
                pin_function_select <= reg_wdata;
            end
        end
    end

    // enable follows the mode being written, so the pin is claimed the edge after the write
    wire [1:0] next_out_en_mode = wr_out ? reg_wdata[1:0] : timer_output_mode;

    // counter, flag and output pin
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            count <= reload_event_timer_pkg::COUNT_RST;
            flag <= 1'b0;
            out_level <= 1'b0;
            out_en <= 1'b0;
        end else begin
            count <= next_count;
            flag <= next_flag;
            out_level <= next_out_level;
            out_en <= (next_out_en_mode != reload_event_timer_pkg::OUT_PORT);
        end
    end

    // read data and the coherent lower-count latch
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rdata <= 4'h0;
            count_low_latched <= 4'h0;
        end else begin
            rdata <= next_rdata;
            if (rd_high) begin
                count_low_latched <= count[3:0];
            end
        end
    end

    // ports, all from flip-flops
    assign reg_rdata = rdata;
    assign timer_output_pin = out_level;
    assign timer_output_en = out_en;
    assign overflow_request_flag = flag;
    assign event_pin_select = pin_function_select[reload_event_timer_pkg::EVENT_SEL_BIT];
    assign second_event_select = pin_function_select[reload_event_timer_pkg::SECOND_EVENT_BIT];
    assign stop_control_select = pin_function_select[reload_event_timer_pkg::STOP_CTRL_BIT];
    assign external_interrupt_select = pin_function_select[reload_event_timer_pkg::EXT_INT_BIT];

    // checks on the design's own behaviour
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    a_upper_load: assert property (wr_high |=>
        count == {$past(reg_wdata), $past(preload_low_nibble)})
        else $error("upper write did not load counter");
    a_low_no_load: assert property (wr_low && !tick |=> count == $past(count))
        else $error("low write changed counter");
    a_count_step: assert property (tick && !at_max && !load |=>
        count == $past(count) + 8'h01)
        else $error("counter did not step on tick");
    a_wrap_free: assert property (overflow && !reload_on |=> count == 8'h00)
        else $error("free-running wrap not zero");
    a_wrap_reload: assert property (overflow && reload_on |=>
        count == $past(reload_value))
        else $error("reload wrap wrong value");
    a_flag_set: assert property (overflow |=> flag ##1 (flag || $past(flag_clear)))
        else $error("overflow flag not set or lost");
    a_flag_sticky: assert property (flag && !flag_clear |=> flag)
        else $error("flag dropped without clear");
    a_toggle_out: assert property (overflow && out_mode == 2'h1 |=>
        timer_output_pin != $past(timer_output_pin))
        else $error("toggle output did not invert");
    a_force_low: assert property (overflow && out_mode == 2'h2 |=> !timer_output_pin)
        else $error("force-low output not low");
    a_force_high: assert property (overflow && out_mode == 2'h3 |=> timer_output_pin)
        else $error("force-high output not high");
    a_mode_delay: assert property (wr_mode |=> ##1 timer_mode_one == $past(reg_wdata, 2))
        else $error("mode write took wrong delay");
    a_read_latch: assert property (rd_high |=>
        reg_rdata == $past(count[7:4]) && count_low_latched == $past(count[3:0]))
        else $error("upper read not coherent");
    a_event_count: assert property (clk_sel == 3'h7 && !load && !at_max &&
        pin_function_select[0] && evt_prev && !evt_sync |=> count == $past(count) + 8'h01)
        else $error("event edge not counted");
    a_pin_enable: assert property (wr_out |=> timer_output_en == ($past(reg_wdata[1:0]) != 2'h0))
        else $error("output enable wrong after mode write");

    // preload storage: each nibble changes only on its own write
    a_low_store: assert property (wr_low |=>
        preload_low_nibble == $past(reg_wdata))
        else $error("low preload not stored");

    a_high_store: assert property (wr_high |=>
        preload_high_nibble == $past(reg_wdata))
        else $error("high preload not stored");

    a_low_hold: assert property (!wr_low |=>
        $stable(preload_low_nibble))
        else $error("low preload changed without write");

    // counter holds unless a tick or a load moves it
    a_count_idle: assert property (!tick && !load |=>
        count == $past(count))
        else $error("counter moved without tick");

    a_load_no_ovf: assert property (load |->
        !overflow)
        else $error("overflow during software load");

    a_ovf_at_max: assert property (overflow |->
        count == 8'hFF)
        else $error("overflow below full count");

    // flag set and clear paths
    a_flag_clear: assert property (flag_clear && !overflow |=>
        !flag)
        else $error("flag not cleared by write");

    a_flag_keep: assert property (wr_flag && reg_wdata[0] && flag |=>
        flag)
        else $error("writing one dropped the flag");

    a_flag_cause: assert property (!flag |=>
        !flag || $past(overflow))
        else $error("flag set without overflow");

    // output pin only moves on overflow, and port mode leaves it alone
    a_port_hold: assert property (overflow && out_mode == 2'h0 |=>
        timer_output_pin == $past(timer_output_pin))
        else $error("port mode changed output");

    a_quiet_out: assert property (!overflow |=>
        timer_output_pin == $past(timer_output_pin))
        else $error("output moved without overflow");

    a_en_hold: assert property (!wr_out |=>
        timer_output_en == $past(timer_output_en))
        else $error("output enable moved without write");

    // output mode register write and read back
    a_out_write: assert property (wr_out |=>
        timer_output_mode == $past(reg_wdata[1:0]))
        else $error("output mode not stored");

    a_out_hold: assert property (!wr_out |=>
        $stable(timer_output_mode))
        else $error("output mode changed without write");

    a_out_read: assert property (rd_out |=>
        reg_rdata == {2'h0, $past(timer_output_mode)})
        else $error("output mode read wrong");

    // read port: latched low nibble and idle zero
    a_low_read: assert property (rd_low |=>
        reg_rdata == $past(count_low_latched))
        else $error("latched low read wrong");

    a_latch_hold: assert property (!rd_high |=>
        $stable(count_low_latched))
        else $error("low latch moved without upper read");

    a_rdata_idle: assert property (!reg_rd |=>
        reg_rdata == 4'h0)
        else $error("read data not zero when idle");

    // pin function register
    a_pin_write: assert property (wr_pin |=>
        pin_function_select == $past(reg_wdata))
        else $error("pin function not stored");

    a_pin_hold: assert property (!wr_pin |=>
        $stable(pin_function_select))
        else $error("pin function changed without write");

    // event ticks need the pin function; the chain keeps its order
    a_event_gate: assert property (clk_sel == 3'h7 && !pin_function_select[0] |->
        !tick)
        else $error("event tick without pin function");

    a_sync_chain: assert property (1'b1 |=>
        evt_sync == $past(evt_meta) && evt_prev == $past(evt_sync))
        else $error("event synchroniser out of order");

    // mode staging and the free prescaler
    a_mode_stage: assert property (wr_mode |=>
        mode_stage == $past(reg_wdata))
        else $error("mode write not staged");

    a_mode_hold: assert property (!wr_mode |=>
        $stable(mode_stage))
        else $error("mode stage moved without write");

    a_prescale_step: assert property (1'b1 |=>
        prescale == $past(prescale) + 11'h001)
        else $error("prescaler did not step");
endmodule
`default_nettype wire

// *** verif/event_source.sv ***
`timescale 1ns/1ps
`default_nettype none
// far side: drives the event pin and loads the timer output pin
module event_source (
    input wire logic core_clk,
    input wire logic timer_output_pin,
    input wire logic timer_output_en,
    output logic event_input_pin
);
    int toggles;
    logic last;
    initial begin
        event_input_pin = 1'b1; // idle high, only falling edges count
        toggles = 0;
        last = 1'b0;
    end
    // load side counts level changes only while the pin is claimed
    always @(posedge core_clk) begin
        if (timer_output_en === 1'b1 && timer_output_pin !== last) toggles++;
        last <= timer_output_pin;
    end
    // each pulse is held 4 cycles low and at least 5 high, well past the synchroniser
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge core_clk);
            event_input_pin <= 1'b0;
            repeat (4) @(posedge core_clk);
            event_input_pin <= 1'b1;
            repeat (4) @(posedge core_clk);
        end
        repeat (4) @(posedge core_clk);
    endtask
endmodule
`default_nettype wire

// *** verif/reload_event_timer_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module reload_event_timer_tb;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [5:0] reg_addr;
    logic [3:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    wire logic [3:0] reg_rdata;
    wire logic event_input_pin, timer_output_pin, timer_output_en, overflow_request_flag;
    wire logic ev_sel, ev2_sel, stop_sel, int_sel;
    int n_fail = 0;
    int compares = 0;
    logic [7:0] v, w;
    logic [3:0] r;
    int t0;
    int per_cnt [4] = '{2, 8, 16, 32};
    always #50 core_clk = ~core_clk;
    reload_event_timer reload_event_timer_i (.core_clk(core_clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .event_input_pin(event_input_pin),
        .timer_output_pin(timer_output_pin), .timer_output_en(timer_output_en),
        .overflow_request_flag(overflow_request_flag), .event_pin_select(ev_sel),
        .second_event_select(ev2_sel), .stop_control_select(stop_sel),
        .external_interrupt_select(int_sel));
    event_source event_source_i (.core_clk(core_clk), .timer_output_pin(timer_output_pin),
        .timer_output_en(timer_output_en), .event_input_pin(event_input_pin));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [3:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [5:0] a, output logic [3:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // upper nibble first so the lower one comes from the latch
    task automatic rd_count(output logic [7:0] c);
        rd(6'h0B, c[7:4]);
        rd(6'h0A, c[3:0]);
    endtask
    task automatic set_mode(input logic [3:0] m);
        wr(6'h09, m);
        repeat (3) @(posedge core_clk); // mode settles before any preload write
    endtask
    task automatic wrap_up;
        if (n_fail == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        #3000000;
        n_fail++;
        wrap_up();
    end
    initial begin
        reg_addr <= 6'h00;
        reg_wdata <= 4'h0;
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (20) @(posedge core_clk);
        sys_rst <= 1'b0;
        #1 chk({1'b0, timer_output_pin, timer_output_en, overflow_request_flag,
            int_sel, stop_sel, ev2_sel, ev_sel}, 8'h00);
        rd(6'h13, r); chk(r, 4'h0);
        rd(6'h02, r); chk(r, 4'h0);
        rd(6'h09, r); chk(r, 4'h0);
        rd(6'h3F, r); chk(r, 4'h0);
        wr(6'h3F, 4'hF);
        rd_count(v); chk(v, 8'h00);
        // split-digit loads, still on the slow 2048 tap
        wr(6'h0A, 4'h3); rd_count(v); chk(v, 8'h00);
        wr(6'h0B, 4'h5); rd_count(v); chk(v, 8'h53);
        wr(6'h0B, 4'hC); rd_count(v); chk(v, 8'hC3);
        wr(6'h0A, 4'h9); rd_count(v); chk(v, 8'hC3);
        for (int i = 0; i < 4; i++) begin
            wr(6'h25, 4'(1 << i));
            #1 chk({4'h0, int_sel, stop_sel, ev2_sel, ev_sel}, 8'(1 << i));
        end
        wr(6'h25, 4'h1);
        set_mode(4'h7);
        wr(6'h0A, 4'h0); wr(6'h0B, 4'h1);
        event_source_i.pulses(5);
        rd_count(v); chk(v, 8'h15);
        wr(6'h0A, 4'hE); wr(6'h0B, 4'hF);
        event_source_i.pulses(3);
        rd_count(v); chk(v, 8'h01);
        chk(8'(overflow_request_flag), 8'h01);
        rd(6'h02, r); chk(r, 4'h1);
        wr(6'h02, 4'h0); rd(6'h02, r); chk(r, 4'h0);
        set_mode(4'hF);
        wr(6'h0B, 4'hF);
        event_source_i.pulses(3);
        rd_count(v); chk(v, 8'hFF);
        // output modes: force high, force low and toggle each stepped by exact event counts, then port mode releases the pin
        wr(6'h13, 4'h3); #1 chk(8'(timer_output_en), 8'h01);
        rd(6'h13, r); chk(r, 4'h3);
        event_source_i.pulses(1); chk(8'(timer_output_pin), 8'h01);
        wr(6'h13, 4'h2);
        event_source_i.pulses(2); chk(8'(timer_output_pin), 8'h00);
        wr(6'h13, 4'h1);
        t0 = event_source_i.toggles;
        event_source_i.pulses(2); chk(8'(timer_output_pin), 8'h01);
        event_source_i.pulses(2); chk(8'(timer_output_pin), 8'h00);
        chk(8'(event_source_i.toggles - t0), 8'h02);
        wr(6'h13, 4'h0); @(posedge core_clk);
        #1 chk(8'(timer_output_en), 8'h00);
        // prescaler taps: ticks over 64 cycles between two latched reads
        for (int s = 0; s < 4; s++) begin
            set_mode(4'(3 + s));
            rd_count(v);
            repeat (60) @(posedge core_clk);
            rd_count(w);
            chk(w - v, 8'(per_cnt[s]));
        end
        // second reset in mid-run
        sys_rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        #1 chk({1'b0, timer_output_pin, timer_output_en, overflow_request_flag,
            int_sel, stop_sel, ev2_sel, ev_sel}, 8'h00);
        wr(6'h0B, 4'h4); rd_count(v); chk(v, 8'h40);
        wrap_up();
    end
endmodule
`default_nettype wire
